// ==== include/dnm_defines.vh ====
// constants for the numeric oscillator and phase modulator
`ifndef DNM_DEFINES_VH
`define DNM_DEFINES_VH
`define DNM_ACC_W 32
`define DNM_PHASE_W 12
`define DNM_AMP_W 10
`define DNM_DATA_W 16
`define DNM_ADDR_W 3
`define DNM_ADDR_F0_LO 3'h0
`define DNM_ADDR_F0_HI 3'h1
`define DNM_ADDR_F1_LO 3'h2
`define DNM_ADDR_F1_HI 3'h3
`define DNM_ADDR_PH_BIT 2
`define DNM_LATENCY 6
`define DNM_ACC_RESET 32'h00000000
`define DNM_AMP_MID 10'h200
`endif

// ==== rtl/dnm_phase_modulator.v ====
// numeric oscillator with phase modulator, parallel write port and sine output
`include "dnm_defines.vh"
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// RQ1: phase accumulator is 32 bits, full scale equals one output cycle.
// RQ2: freq_select low steps by frequency word 0, high by word 1.
// RQ3: switching frequency words never touches accumulator contents.
// RQ4: selected 12-bit offset adds to accumulator top bits before lookup.
// RQ5: four offset registers, each step is one 4096th of a cycle.
// RQ6: offset phase truncated to 12 bits addresses the sine table.
// RQ7: sine table gives 10-bit codes from a 12-bit phase address.
// RQ8: output frequency is word times clock rate over two to the 32.
// RQ9: each write moves one 16-bit word to the register reg_addr picks.
// RQ10: offset writes keep the low 12 data bits, drop the top 4.
// RQ11: data and address are captured on write strobe rising edge.
// RQ12: captured word lands in its register on the next clock edge; here on the third clock edge after the strobe rises.
// RQ13: host keeps strobe edge away from clock edges, else one cycle uncertainty.
// RQ14: select inputs sampled on clock edges; host holds them stable there.
// RQ15: select changes and writes reach the output six cycles later; writes here take seven, from the first clock edge seeing the strobe high.
// RQ16: reset clears the accumulator, output goes to midscale.
// RQ17: reset leaves frequency and offset registers alone.
// RQ18: host resets, zeroes registers, then loads working values.
// RQ19: addresses 0-3 frequency word halves, 4-7 phase offsets 0-3.
// RQ20: offset index is phase_sel_hi then phase_sel_lo as low bit.
// RQ21: sleep low halts internal operation, high resumes it.
// RQ22: accumulator adds selected word each clock, wraps silently.
module dnm_phase_modulator #(
  parameter ACC_W = `DNM_ACC_W,
  parameter PHASE_W = `DNM_PHASE_W,
  parameter AMP_W = `DNM_AMP_W
) (
  // clock and reset
  input wire clock,
  input wire reset,
  // low power control
  input wire sleep_n,
  // parallel write port
  input wire write_strobe_n,
  input wire [`DNM_ADDR_W-1:0] reg_addr,
  input wire [`DNM_DATA_W-1:0] data_bus,
  // select inputs
  input wire freq_select,
  input wire phase_sel_lo,
  input wire phase_sel_hi,
  // converter code
  output reg [AMP_W-1:0] dac_code
);
  // pin synchronisers
  reg [1:0] strobe_sync_reg;
  reg strobe_prev_reg;
  reg [2:0] sel_meta_reg;
  reg [2:0] sel_sync_reg;
  reg [1:0] sleep_sync_reg;
  reg [`DNM_ADDR_W-1:0] addr_meta_reg;
  reg [`DNM_ADDR_W-1:0] addr_sync_reg;
  reg [`DNM_DATA_W-1:0] data_meta_reg;
  reg [`DNM_DATA_W-1:0] data_sync_reg;
  // register file
  reg [ACC_W-1:0] freq_word_0;
  reg [ACC_W-1:0] freq_word_1;
  reg [PHASE_W-1:0] phase_offset_0;
  reg [PHASE_W-1:0] phase_offset_1;
  reg [PHASE_W-1:0] phase_offset_2;
  reg [PHASE_W-1:0] phase_offset_3;
  // datapath
  reg [ACC_W-1:0] acc_reg;
  reg [ACC_W-1:0] step_reg;
  reg [PHASE_W-1:0] offset_reg;
  reg [PHASE_W-1:0] offset_d_reg;
  reg [PHASE_W-1:0] addr_reg;
  reg mid_reg;
  reg mid_d_reg;
  wire [AMP_W-1:0] table_amp;
  wire run;
  wire strobe_rise;
  wire [PHASE_W-1:0] sel_offset;
  assign run = sleep_sync_reg[1]; // RQ21
  assign strobe_rise = strobe_sync_reg[1] & ~strobe_prev_reg; // RQ11
  // synchronise pins; data and address travel with the strobe
  always @(posedge clock) begin
    strobe_sync_reg <= {strobe_sync_reg[0], write_strobe_n};
    strobe_prev_reg <= strobe_sync_reg[1];
    sel_meta_reg <= {phase_sel_hi, phase_sel_lo, freq_select};
    sel_sync_reg <= sel_meta_reg; // RQ14
    sleep_sync_reg <= {sleep_sync_reg[0], sleep_n};
    addr_meta_reg <= reg_addr;
    addr_sync_reg <= addr_meta_reg;
    data_meta_reg <= data_bus;
    data_sync_reg <= data_meta_reg;
  end
  // register writes; reset does not touch these
  always @(posedge clock) begin // RQ17
    if (strobe_rise) begin // RQ12
      if (addr_sync_reg == `DNM_ADDR_F0_LO) begin // RQ19
        freq_word_0[15:0] <= data_sync_reg; // RQ9
      end else if (addr_sync_reg == `DNM_ADDR_F0_HI) begin
        freq_word_0[31:16] <= data_sync_reg;
      end else if (addr_sync_reg == `DNM_ADDR_F1_LO) begin
        freq_word_1[15:0] <= data_sync_reg;
      end else if (addr_sync_reg == `DNM_ADDR_F1_HI) begin
        freq_word_1[31:16] <= data_sync_reg;
      end else if (addr_sync_reg[1:0] == 2'h0) begin
        phase_offset_0 <= data_sync_reg[PHASE_W-1:0]; // RQ10
      end else if (addr_sync_reg[1:0] == 2'h1) begin
        phase_offset_1 <= data_sync_reg[PHASE_W-1:0];
      end else if (addr_sync_reg[1:0] == 2'h2) begin
        phase_offset_2 <= data_sync_reg[PHASE_W-1:0];
      end else begin
        phase_offset_3 <= data_sync_reg[PHASE_W-1:0];
      end
    end
  end
  assign sel_offset = sel_sync_reg[2] ? (sel_sync_reg[1] ? phase_offset_3 : phase_offset_2)
                                      : (sel_sync_reg[1] ? phase_offset_1 : phase_offset_0); // RQ20
  // pipeline: step select, accumulate, offset add, table, output
  always @(posedge clock) begin
    if (reset) begin
      acc_reg <= `DNM_ACC_RESET; // RQ16
      step_reg <= {ACC_W{1'b0}};
      offset_reg <= {PHASE_W{1'b0}};
      offset_d_reg <= {PHASE_W{1'b0}};
      addr_reg <= {PHASE_W{1'b0}};
      mid_reg <= 1'b1;
      mid_d_reg <= 1'b1;
      dac_code <= `DNM_AMP_MID;
    end else if (run) begin
      step_reg <= sel_sync_reg[0] ? freq_word_1 : freq_word_0; // RQ2
      offset_reg <= sel_offset; // RQ5
      offset_d_reg <= offset_reg; // RQ15
      acc_reg <= acc_reg + step_reg; // RQ1 RQ3 RQ8 RQ22
      addr_reg <= acc_reg[ACC_W-1 -: PHASE_W] + offset_d_reg; // RQ4 RQ6
      mid_reg <= 1'b0;
      mid_d_reg <= mid_reg;
      dac_code <= mid_d_reg ? `DNM_AMP_MID : table_amp; // RQ7 RQ15
    end
  end
  dnm_sine_table #(
    .ADDR_W(PHASE_W),
    .DATA_W(AMP_W)
  ) u_table (
    .clock(clock),
    .enable(run),
    .phase_addr(addr_reg),
    .amplitude(table_amp)
  );
endmodule // dnm_phase_modulator
`default_nettype wire

// ==== rtl/dnm_sine_table.v ====
// sine amplitude table with registered read data
`timescale 1ns/10ps
`default_nettype none
module dnm_sine_table #(
  parameter ADDR_W = 12,
  parameter DATA_W = 10
) (
  // clock and enable
  input wire clock,
  input wire enable,
  // lookup
  input wire [ADDR_W-1:0] phase_addr,
  output reg [DATA_W-1:0] amplitude
);
  localparam DEPTH = 1 << ADDR_W;
  reg [DATA_W-1:0] table_mem [0:DEPTH-1];
  integer i;
  integer code;
  real mid;
  initial begin
    mid = (1 << (DATA_W - 1)) - 0.5;
    for (i = 0; i < DEPTH; i = i + 1) begin
      code = $rtoi(mid + 0.5 + mid * $sin(6.283185307179586 * i / DEPTH));
      table_mem[i] = code[DATA_W-1:0];
    end
  end
  always @(posedge clock) begin
    if (enable) begin
      amplitude <= table_mem[phase_addr];
    end
  end
endmodule // dnm_sine_table
`default_nettype wire

// ==== testbench/dnm_host.sv ====
// host model driving the parallel write port
`timescale 1ns/10ps
`default_nettype none
module dnm_host (
  // clock
  input wire logic clock,
  // write port
  output logic write_strobe_n,
  output logic [2:0] reg_addr,
  output logic [15:0] data_bus
);
  initial begin
    write_strobe_n = 1'b1;
    reg_addr = 3'h0;
    data_bus = 16'h0000;
  end
  task wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    data_bus <= d;
    write_strobe_n <= 1'b0;
    repeat (4) @(posedge clock);
    write_strobe_n <= 1'b1;
    repeat (4) @(posedge clock);
    reg_addr <= ~a;
    data_bus <= ~d;
  endtask
endmodule // dnm_host
`default_nettype wire

// ==== testbench/dnm_monitor.sv ====
// port checker for the phase modulator
`timescale 1ns/10ps
`default_nettype none
module dnm_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // inputs
  input wire logic sleep_n,
  input wire logic write_strobe_n,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] data_bus,
  input wire logic freq_select,
  input wire logic phase_sel_lo,
  input wire logic phase_sel_hi,
  // output
  input wire logic [9:0] dac_code
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic [15:0] w_reg [4];
  logic [2:0] s_reg;
  logic [3:0] q_reg;
  wire [2:0] s = {freq_select, phase_sel_hi, phase_sel_lo};
  wire chg = s != s_reg;
  wire calm = (w_reg[0] | w_reg[1] | w_reg[2] | w_reg[3]) == 16'h0 && q_reg == 4'hf;
  always @(posedge clock) begin
    s_reg <= s;
    if (reset || !sleep_n || !write_strobe_n || chg) q_reg <= 4'h0;
    else if (q_reg != 4'hf) q_reg <= q_reg + 4'h1;
    if ($rose(write_strobe_n) && !reg_addr[2]) w_reg[reg_addr[1:0]] <= data_bus;
  end
  AST_RST_MID: assert property (disable iff (!sleep_n) reset [*5] |-> dac_code == 10'h200)
    else $error("no midscale in reset");
  AST_REL_MID: assert property (sleep_n && $fell(reset) |-> dac_code == 10'h200 ##1 dac_code == 10'h200)
    else $error("no midscale after reset");
  AST_RST_STAY: assert property (disable iff (!sleep_n) reset [*6] |-> $stable(dac_code))
    else $error("output moves in reset");
  AST_SLP_FRZ: assert property (!sleep_n [*4] |-> $stable(dac_code))
    else $error("output moves in sleep");
  AST_SLP_WAKE: assert property (!sleep_n [*3] ##1 sleep_n |-> $stable(dac_code) [*2])
    else $error("early wake");
  AST_HOLD: assert property (calm |-> $stable(dac_code))
    else $error("output moves with zero step");
  AST_SEL_LAT: assert property (calm && chg |-> $stable(dac_code) [*5])
    else $error("select too early");
  AST_WR_LAT: assert property (calm && $fell(write_strobe_n) |-> $stable(dac_code) [*8])
    else $error("write too early");
endmodule // dnm_monitor
bind dnm_phase_modulator dnm_monitor i_dnm_monitor (.clock, .reset, .sleep_n, .write_strobe_n,
  .reg_addr, .data_bus, .freq_select, .phase_sel_lo, .phase_sel_hi, .dac_code);
`default_nettype wire

// ==== testbench/tb_top.sv ====
// testbench for the phase modulator
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clock, reset, sleep_n, freq_select, phase_sel_lo, phase_sel_hi;
  wire write_strobe_n;
  wire [2:0] reg_addr;
  wire [15:0] data_bus;
  wire [9:0] dac_code;
  integer n_errors, n_tests, seed, s, j, k, ok, m;
  logic [15:0] d;
  logic [11:0] off [4];
  logic [9:0] v [8];
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  dnm_host i_dnm_host (.clock, .write_strobe_n, .reg_addr, .data_bus);
  dnm_phase_modulator i_dnm_phase_modulator (.clock, .reset, .sleep_n, .write_strobe_n,
    .reg_addr, .data_bus, .freq_select, .phase_sel_lo, .phase_sel_hi, .dac_code);
  function automatic logic [9:0] tab(input integer i);
    tab = 10'(int'(511.5 + 511.5 * $sin(6.283185307179586 * (i & 4095) / 4096.0)));
  endfunction
  task give_verdict;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // eight samples must match some phase of the expected sequence
  task run(input integer st, input integer o, input integer kn);
    repeat (12) @(posedge clock);
    for (j = 0; j < 8; j++) begin
      @(negedge clock);
      v[j] = dac_code;
    end
    ok = 0;
    for (k = 0; k < kn; k++) begin
      m = 1;
      for (j = 0; j < 8; j++) if (v[j] !== tab(o + k + st * j)) m = 0;
      if (m) ok = 1;
    end
    n_tests++;
    if (!ok) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, v[0], tab(o));
    end
  endtask
  initial begin
    n_errors = 0;
    n_tests = 0;
    seed = 32'h83c0;
    reset = 1'b1;
    sleep_n = 1'b1;
    {freq_select, phase_sel_hi, phase_sel_lo} = 3'h0;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    for (s = 0; s < 4; s++) i_dnm_host.wr(s[2:0], 16'h0000);
    for (s = 0; s < 4; s++) begin
      d = 16'($random(seed));
      off[s] = d[11:0];
      i_dnm_host.wr({1'b1, s[1:0]}, d);
    end
    reset <= 1'b1;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    for (s = 0; s < 8; s++) begin
      {freq_select, phase_sel_hi, phase_sel_lo} <= s[2:0];
      run(0, off[s[1:0]], 1);
    end
    i_dnm_host.wr(3'h1, 16'hc000);
    i_dnm_host.wr(3'h3, 16'h0010);
    {freq_select, phase_sel_hi, phase_sel_lo} <= 3'h5;
    run(1, off[1], 4096);
    sleep_n <= 1'b0;
    repeat (6) @(posedge clock);
    sleep_n <= 1'b1;
    run(1, off[1], 4096);
    freq_select <= 1'b0;
    run(3072, off[1], 4096);
    give_verdict;
  end
endmodule // tb_top
`default_nettype wire
